//--- common/dclc_pkg.sv
// ********************************************************************
// constants of the dac channel load control
// ********************************************************************
package dclc_pkg;

  // geometry
  localparam int NUM_CH   = 4;
  localparam int CODE_W   = 16;
  localparam int WORD_W   = 24;

  // command word fields
  localparam int CMD_MSB  = 23;
  localparam int CMD_LSB  = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 0;
  localparam int MASK_MSB = 3;
  localparam int REF_BIT  = 0;

  // command codes
  localparam logic [3:0] CMD_WR_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE   = 4'h2;
  localparam logic [3:0] CMD_WR_BOTH  = 4'h3;
  localparam logic [3:0] CMD_MASK     = 4'h5;
  localparam logic [3:0] CMD_SOFT_RST = 4'h6;
  localparam logic [3:0] CMD_REF      = 4'h7;

  // reset values
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_MID     = 16'h8000;
  localparam logic [3:0]  MASK_RST     = 4'h0;
  localparam logic        REF_CTRL_RST = 1'b0;

  // strobe counted as tied low after this long low
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TIE_LOW_NS     = 1000;
  localparam int TIE_LOW_CYCLES = TIE_LOW_NS / CLK_PERIOD_NS;
  localparam int TIE_CNT_W      = 8;

  // sequencing states
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } dclc_state_t;

endpackage : dclc_pkg

//--- common/dclc_chan_if.sv
`timescale 1ns/1ps
// ********************************************************************
// control path between load control and one channel
// ********************************************************************
interface dclc_chan_if;
  logic        wr_input;
  logic        wr_dac;
  logic        copy;
  logic        preset;
  logic [15:0] data;
  logic [15:0] preset_code;
  logic [15:0] input_code;
  logic [15:0] dac_code;

  modport ctrl (
    output wr_input, wr_dac, copy, preset, data, preset_code,
    input  input_code, dac_code
  );
  modport chan (
    input  wr_input, wr_dac, copy, preset, data, preset_code,
    output input_code, dac_code
  );
endinterface : dclc_chan_if

//--- verilog/dclc_channel.sv
`timescale 1ns/1ps
// ********************************************************************
// one channel: input register and dac register
// ********************************************************************
module dclc_channel
  import dclc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  dclc_chan_if.chan ch
);

  // input register, preset beats a write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch.input_code <= CODE_ZERO;
    end else if (ch.preset) begin
      ch.input_code <= ch.preset_code;
    end else if (ch.wr_input) begin
      ch.input_code <= ch.data;
    end
  end

  // dac register, new data beats a copy of the old input value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch.dac_code <= CODE_ZERO;
    end else if (ch.preset) begin
      ch.dac_code <= ch.preset_code;
    end else if (ch.wr_dac) begin
      ch.dac_code <= ch.data;
    end else if (ch.copy) begin
      ch.dac_code <= ch.input_code;
    end
  end

endmodule : dclc_channel

//--- verilog/dclc_load_control.sv
`timescale 1ns/1ps
module dclc_load_control
  import dclc_pkg::*;
(
  // clock and power-on reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // pins
  input  wire logic               hw_reset_n,
  input  wire logic               reset_level_select,
  input  wire logic               load_strobe_n,
  // received command word, pulse on its last serial bit
  input  wire logic               cmd_valid,
  input  wire logic [WORD_W-1:0]  cmd_word,
  // state
  output logic [NUM_CH*CODE_W-1:0] dac_code,
  output logic [NUM_CH-1:0]        strobe_mask_out,
  output logic                     ref_enable,
  output logic                     initialised
);

  // ******************************************************************
  // declarations
  // ******************************************************************
  dclc_state_t            state;
  dclc_state_t            next_state;
  logic [NUM_CH-1:0]      strobe_mask;
  logic                   reference_control;
  logic                   strobe_prev;
  logic                   strobe_fall;
  logic [TIE_CNT_W-1:0]   tie_cnt;
  logic                   tied_low;
  logic                   run;
  logic                   hit;
  logic                   preset;
  logic                   soft_rst;
  logic [3:0]             op;
  logic [3:0]             addr;
  logic [CODE_W-1:0]      data;
  logic [CODE_W-1:0]      preset_code;
  logic [NUM_CH-1:0]      eff_low;
  logic [CODE_W-1:0]      in0;

  dclc_chan_if ch_if [NUM_CH] ();

  // ******************************************************************
  // command word split
  // ******************************************************************
  assign op   = cmd_word[CMD_MSB:CMD_LSB];
  assign addr = cmd_word[ADDR_MSB:ADDR_LSB];
  assign data = cmd_word[DATA_MSB:DATA_LSB];

  // ******************************************************************
  // reset sequencing
  // ******************************************************************
  // next state of the reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (hw_reset_n) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!hw_reset_n) next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (hw_reset_n) next_state = ST_RUN;
      end
      default: next_state = ST_INIT;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  assign run         = (state == ST_RUN);
  assign initialised = (state != ST_INIT);
  // commands refused while the reset pin is low
  assign hit         = run && hw_reset_n && cmd_valid;
  assign soft_rst    = hit && (op == CMD_SOFT_RST);
  // preset on leaving init, every cycle of a held reset, or by command
  assign preset      = (state == ST_INIT && hw_reset_n)
                     || (next_state == ST_HOLD)
                     || (state == ST_HOLD)
                     || soft_rst;
  assign preset_code = reset_level_select ? CODE_MID : CODE_ZERO;

  // ******************************************************************
  // strobe edge and tie-low detection
  // ******************************************************************
  // previous strobe level, parked high outside normal running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_prev <= 1'b1;
    end else if (!run) begin
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= load_strobe_n;
    end
  end

  assign strobe_fall = run && strobe_prev && !load_strobe_n;

  // low-time counter, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tie_cnt <= '0;
    end else if (load_strobe_n) begin
      tie_cnt <= '0;
    end else if (!tied_low) begin
      tie_cnt <= tie_cnt + 1'b1;
    end
  end

  // tie-low state drops at once when the strobe goes high
  assign tied_low = !load_strobe_n
                  && (tie_cnt >= TIE_CNT_W'(TIE_LOW_CYCLES));

  // ******************************************************************
  // control registers
  // ******************************************************************
  // strobe mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_mask <= MASK_RST;
    end else if (preset) begin
      strobe_mask <= MASK_RST;
    end else if (hit && op == CMD_MASK) begin
      strobe_mask <= data[MASK_MSB:0];
    end
  end

  // reference control, zero keeps the reference running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reference_control <= REF_CTRL_RST;
    end else if (soft_rst) begin
      reference_control <= REF_CTRL_RST;
    end else if (hit && op == CMD_REF) begin
      reference_control <= data[REF_BIT];
    end
  end

  assign ref_enable      = !reference_control;
  assign strobe_mask_out = strobe_mask;

  // ******************************************************************
  // per-channel steering
  // ******************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // effective strobe level seen by this channel
      assign eff_low[gi] = tied_low
                         || (!load_strobe_n && !strobe_mask[gi]);

      assign ch_if[gi].wr_input = hit && addr[gi]
                                && (op == CMD_WR_INPUT
                                 || op == CMD_WR_BOTH);
      assign ch_if[gi].wr_dac   = hit && addr[gi]
                                && (op == CMD_WR_BOTH
                                 || (op == CMD_WR_INPUT
                                     && eff_low[gi]));
      assign ch_if[gi].copy     = (hit && addr[gi]
                                   && op == CMD_UPDATE)
                                || (strobe_fall
                                   && !strobe_mask[gi]);
      assign ch_if[gi].preset      = preset;
      assign ch_if[gi].data        = data;
      assign ch_if[gi].preset_code = preset_code;
      assign dac_code[gi*CODE_W +: CODE_W] = ch_if[gi].dac_code;

      dclc_channel u_channel (
        .clk    (clk),
        .arst_n (arst_n),
        .ch     (ch_if[gi])
      );

      // per-channel checks on the dac register
      AST_CH_WR_BOTH: assert property (
        @(posedge clk) disable iff (!arst_n)
        (hit && op == CMD_WR_BOTH && addr[gi])
        |=> ch_if[gi].dac_code == $past(data))
        else $error("channel missed a write-both command");

      AST_CH_EDGE: assert property (
        @(posedge clk) disable iff (!arst_n)
        (strobe_fall && !strobe_mask[gi] && !(hit && addr[gi]) && !preset)
        |=> ch_if[gi].dac_code == $past(ch_if[gi].input_code))
        else $error("strobe fall did not load an unmasked channel");

      AST_CH_MASKED: assert property (
        @(posedge clk) disable iff (!arst_n)
        (strobe_fall && strobe_mask[gi] && !tied_low && !preset
         && !(hit && addr[gi]))
        |=> $stable(ch_if[gi].dac_code))
        else $error("masked channel took a strobe fall");

      AST_CH_UPDATE: assert property (
        @(posedge clk) disable iff (!arst_n)
        (hit && op == CMD_UPDATE && addr[gi])
        |=> ch_if[gi].dac_code == $past(ch_if[gi].input_code))
        else $error("update command missed a channel");

      AST_CH_WR_LOW: assert property (
        @(posedge clk) disable iff (!arst_n)
        (hit && op == CMD_WR_INPUT && addr[gi] && eff_low[gi])
        |=> ch_if[gi].dac_code == $past(data))
        else $error("strobe-low write did not reach the dac");
    end
  endgenerate

  assign in0 = ch_if[0].input_code;

  // ******************************************************************
  // assertions on channel 0, mask, reference and initialisation
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_WR_INPUT_HELD: assert property (
    (hit && op == CMD_WR_INPUT && addr[0] && !eff_low[0] && !preset)
    |=> $stable(dac_code[CODE_W-1:0]) && in0 == $past(data))
    else $error("dac moved on input write with strobe high");

  AST_WR_INPUT_LOW: assert property (
    (hit && op == CMD_WR_INPUT && addr[0] && eff_low[0])
    |=> dac_code[CODE_W-1:0] == $past(data) && in0 == $past(data))
    else $error("dac not updated on input write with strobe low");

  AST_UPDATE: assert property (
    (hit && op == CMD_UPDATE && addr[0])
    |=> dac_code[CODE_W-1:0] == $past(in0) && $stable(in0))
    else $error("update command did not copy input to dac");

  AST_WR_BOTH: assert property (
    (hit && op == CMD_WR_BOTH && addr[0])
    |=> dac_code[CODE_W-1:0] == $past(data) && in0 == $past(data))
    else $error("write-both command missed a register");

  AST_EDGE_COPY: assert property (
    (run && $past(load_strobe_n) && !load_strobe_n && !strobe_mask[0]
     && !(hit && addr[0]) && !preset)
    |=> dac_code[CODE_W-1:0] == $past(in0))
    else $error("strobe edge did not load unmasked channel");

  AST_MASK_BLOCKS: assert property (
    (strobe_fall && strobe_mask[0] && !tied_low
     && !(hit && addr[0]) && !preset)
    |=> $stable(dac_code[CODE_W-1:0]))
    else $error("masked channel followed strobe edge");

  AST_MASK_LOAD: assert property (
    (hit && op == CMD_MASK) |=> strobe_mask_out == $past(data[3:0]))
    else $error("mask not loaded from low data bits");

  AST_RESET_HOLD: assert property (
    (state == ST_HOLD) ##1 (state == ST_HOLD)
    |-> dac_code[CODE_W-1:0] == $past(preset_code))
    else $error("output not held at cleared code in reset");

  AST_REF: assert property (
    (hit && op == CMD_REF) |=> ref_enable == !$past(data[0]))
    else $error("reference control not taken from bit zero");

  AST_INIT_WAIT: assert property (
    (state == ST_INIT && !hw_reset_n) |=> !initialised)
    else $error("initialised while reset pin held low");

  // ******************************************************************
  // assertions on reset, tie-low override, input register, reference and mask
  // ******************************************************************
  AST_SOFT_RESET: assert property (
    soft_rst
    |=> dac_code[CODE_W-1:0] == $past(preset_code)
        && strobe_mask_out == MASK_RST && ref_enable)
    else $error("soft reset did not restore power-on state");

  AST_POWER_UP_CODE: assert property (
    (state == ST_INIT && hw_reset_n)
    |=> dac_code[CODE_W-1:0] == $past(preset_code)
        && in0 == $past(preset_code))
    else $error("power-up code not loaded");

  AST_RESET_ENTRY: assert property (
    (run && !hw_reset_n)
    |=> dac_code[CODE_W-1:0] == $past(preset_code) && state == ST_HOLD)
    else $error("reset pin did not clear the output");

  AST_HOLD_REFUSE: assert property (
    (state == ST_HOLD && cmd_valid)
    |=> dac_code[CODE_W-1:0] == $past(preset_code))
    else $error("command accepted while reset pin low");

  AST_INIT_FROZEN: assert property (
    (state == ST_INIT && !hw_reset_n)
    |=> $stable(dac_code) && $stable(strobe_mask_out))
    else $error("state moved before initialisation");

  AST_TIED_OVERRIDE: assert property (
    (hit && op == CMD_WR_INPUT && addr[0] && tied_low && strobe_mask[0])
    |=> dac_code[CODE_W-1:0] == $past(data))
    else $error("tied-low strobe did not override the mask");

  AST_INPUT_KEPT: assert property (
    (!hit && !preset) |=> $stable(in0))
    else $error("input register moved without a write");

  AST_MASK_KEPT: assert property (
    (!(hit && op == CMD_MASK) && !preset) |=> $stable(strobe_mask_out))
    else $error("mask changed without a mask command");

  AST_REF_KEPT: assert property (
    (!(hit && op == CMD_REF) && !soft_rst) |=> $stable(ref_enable))
    else $error("reference state changed without a command");

  COV_DEFERRED: cover property (
    (hit && op == CMD_WR_INPUT && load_strobe_n) ##[1:20] strobe_fall);
  COV_HW_RESET: cover property (
    run ##1 (state == ST_HOLD) ##[1:10] run);
  COV_MASKED_EDGE: cover property (strobe_fall && strobe_mask != 4'h0);
  COV_TIED: cover property (tied_low && hit && op == CMD_WR_INPUT);
  COV_SOFT_RESET: cover property (soft_rst && reset_level_select);

endmodule : dclc_load_control

//--- testbench/dclc_cmd_source.sv
`timescale 1ns/1ps
// ********************************************************************
// command source standing in for the serial bus master
// ********************************************************************
module dclc_cmd_source
  import dclc_pkg::*;
(
  // clock
  input  wire logic          clk,
  // received command word
  output logic               cmd_valid,
  output logic [WORD_W-1:0]  cmd_word
);
  logic [WORD_W:0] q[$];   // top bit marks a real word
  logic [WORD_W:0] nxt;

  initial begin
    cmd_valid = 1'b0;
    cmd_word  = 24'h000000;
  end

  // pop at the edge, drive just after it; idle slots slow the master
  always @(posedge clk) begin
    nxt = (q.size() > 0) ? q.pop_front() : {1'b0, ~cmd_word};
    #1;
    cmd_valid = nxt[WORD_W];
    cmd_word  = nxt[WORD_W] ? nxt[WORD_W-1:0] : ~cmd_word;
  end

  // queue one word followed by idle cycles
  task automatic push(input logic [WORD_W-1:0] w, input int gap);
    q.push_back({1'b1, w});
    repeat (gap) q.push_back({1'b0, 24'h000000});
  endtask : push
endmodule : dclc_cmd_source

//--- testbench/dclc_load_control_test.sv
`timescale 1ns/1ps
// ********************************************************************
// self-checking bench for the dac channel load control
// ********************************************************************
module dclc_load_control_test
  import dclc_pkg::*;
;
  logic                      clk;
  logic                      arst_n;
  logic                      hw_reset_n;
  logic                      reset_level_select;
  logic                      load_strobe_n;
  logic                      cmd_valid;
  logic [WORD_W-1:0]         cmd_word;
  logic [NUM_CH*CODE_W-1:0]  dac_code;
  logic [NUM_CH-1:0]         strobe_mask_out;
  logic                      ref_enable;
  logic                      initialised;
  logic [3:0]                c;
  logic [15:0]               d;
  logic [31:0]               r;
  int                        n_fail = 0;
  int                        checked = 0;
  int                        seed;
  int                        gap;
  int                        inp[NUM_CH];
  int                        dac[NUM_CH];
  int                        mask = 0;
  int                        ref_off = 0;
  int                        st = 0;
  int                        init = 0;
  int                        prev = 1;
  int                        tcnt = 0;
  int                        pre;

  assign c = cmd_word[CMD_MSB:CMD_LSB];
  assign d = cmd_word[DATA_MSB:DATA_LSB];

  dclc_load_control u_dclc_load_control (
    .clk                (clk),
    .arst_n             (arst_n),
    .hw_reset_n         (hw_reset_n),
    .reset_level_select (reset_level_select),
    .load_strobe_n      (load_strobe_n),
    .cmd_valid          (cmd_valid),
    .cmd_word           (cmd_word),
    .dac_code           (dac_code),
    .strobe_mask_out    (strobe_mask_out),
    .ref_enable         (ref_enable),
    .initialised        (initialised)
  );

  dclc_cmd_source u_dclc_cmd_source (
    .clk       (clk),
    .cmd_valid (cmd_valid),
    .cmd_word  (cmd_word)
  );

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // bounded wait for the command source to run dry
  task automatic drain();
    for (int i = 0; i < 200 && u_dclc_cmd_source.q.size() > 0; i++) tick(1);
    if (u_dclc_cmd_source.q.size() > 0) begin
      n_fail++;
      give_verdict();
    end
    tick(2);
  endtask : drain

  // reference model of registers and sequencing
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      foreach (dac[i]) dac[i] = 0;
      foreach (inp[i]) inp[i] = 0;
      mask = 0;
      ref_off = 0;
      init = 0;
      st = 0;
      prev = 1;
      tcnt = 0;
    end else begin
      pre = 0;
      tcnt = load_strobe_n ? 0 : tcnt + 1;
      if (!hw_reset_n && st != 0) begin
        pre = 1;
        st = 2;
        prev = 1;
      end else if (hw_reset_n && st != 1) begin
        pre = 1;
        init = 1;
        st = 1;
        prev = 1;
      end else if (st == 1) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (prev && !load_strobe_n && !mask[i]) dac[i] = inp[i];
          if (cmd_valid && cmd_word[ADDR_LSB+i]) begin
            if (c == CMD_WR_INPUT || c == CMD_WR_BOTH) inp[i] = d;
            if (c == CMD_WR_BOTH || c == CMD_WR_INPUT && (tcnt > TIE_LOW_CYCLES
                || !load_strobe_n && !mask[i])) dac[i] = d;
            if (c == CMD_UPDATE) dac[i] = inp[i];
          end
        end
        prev = load_strobe_n;
        if (cmd_valid && c == CMD_MASK) mask = d[MASK_MSB:0];
        if (cmd_valid && c == CMD_REF) ref_off = d[REF_BIT];
        if (cmd_valid && c == CMD_SOFT_RST) begin
          pre = 1;
          mask = 0;
          ref_off = 0;
        end
      end
      if (pre) begin
        mask = 0;
        foreach (inp[i]) begin
          inp[i] = reset_level_select ? CODE_MID : CODE_ZERO;
          dac[i] = inp[i];
        end
      end
    end
  end

  // compare every output on each falling edge
  always @(negedge clk) begin
    for (int i = 0; i < NUM_CH; i++)
      check(dac_code[CODE_W*i +: CODE_W], dac[i][15:0]);
    check({12'h000, strobe_mask_out}, mask[15:0]);
    check({15'h0000, ref_enable}, {15'h0000, ~ref_off[0]});
    check({15'h0000, initialised}, init[15:0]);
  end

  // stimulus
  initial begin
    seed = 32'h3ecb31a6;
    arst_n = 1'b0;
    hw_reset_n = 1'b0;
    reset_level_select = 1'b1;
    load_strobe_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      tick(1);
      load_strobe_n = ~i[0];
    end
    arst_n = 1'b1;
    tick(8);
    hw_reset_n = 1'b1;
    tick(2);
    // masked channels skip the strobe fall
    u_dclc_cmd_source.push({CMD_MASK, 4'h0, 16'h000a}, 0);
    u_dclc_cmd_source.push({CMD_WR_INPUT, 4'hf, 16'h1357}, 1);
    tick(4);
    load_strobe_n = 1'b0;
    tick(2);
    load_strobe_n = 1'b1;
    // random words, strobe and reset level
    for (int n = 0; n < 400; n++) begin
      r = $random(seed);
      gap = r[25:24];
      u_dclc_cmd_source.push(r[23:0], gap);
      tick(1 + gap);
      load_strobe_n = r[26] | r[27];
      reset_level_select = r[28];
    end
    drain();
    // strobe tied low overrides a full mask
    u_dclc_cmd_source.push({CMD_MASK, 4'h0, 16'h000f}, 0);
    tick(2);
    load_strobe_n = 1'b0;
    tick(TIE_LOW_CYCLES + 20);
    u_dclc_cmd_source.push({CMD_WR_INPUT, 4'h5, 16'hbeef}, 2);
    tick(4);
    load_strobe_n = 1'b1;
    // reset pin mid-run, writes refused while held
    u_dclc_cmd_source.push({CMD_MASK, 4'h0, 16'h0000}, 0);
    u_dclc_cmd_source.push({CMD_REF, 4'h0, 16'h0000}, 0);
    u_dclc_cmd_source.push({CMD_WR_BOTH, 4'hf, 16'h4321}, 1);
    tick(5);
    reset_level_select = 1'b0;
    hw_reset_n = 1'b0;
    u_dclc_cmd_source.push({CMD_WR_BOTH, 4'hf, 16'h7777}, 0);
    tick(4);
    hw_reset_n = 1'b1;
    tick(3);
    // second power-on reset in mid-run
    reset_level_select = 1'b1;
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(3);
    u_dclc_cmd_source.push({CMD_WR_INPUT, 4'h2, 16'h0042}, 0);
    tick(3);
    load_strobe_n = 1'b0;
    tick(2);
    give_verdict();
  end
endmodule : dclc_load_control_test
